// ==== rtl/ppm_pkg.sv ====
package ppm_pkg;
    localparam int unsigned NUM_PORTS = 5;
    localparam int unsigned PIN_W     = 8;
    localparam int unsigned P4_PINS   = 4;
    // register indices (printed offsets); byte address is index times four
    localparam logic [7:0] IDX_P1_LOW  = 8'h91;
    localparam logic [7:0] IDX_P1_HIGH = 8'h92;
    localparam logic [7:0] IDX_P0_LOW  = 8'h93;
    localparam logic [7:0] IDX_P0_HIGH = 8'h94;
    localparam logic [7:0] IDX_P2_LOW  = 8'h95;
    localparam logic [7:0] IDX_P2_HIGH = 8'h96;
    localparam logic [7:0] IDX_P3_LOW  = 8'hB1;
    localparam logic [7:0] IDX_P3_HIGH = 8'hB2;
    localparam logic [7:0] IDX_P4_LOW  = 8'hB3;
    localparam logic [7:0] IDX_P4_HIGH = 8'hB4;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] P4_MASK     = 8'h0F;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
    // strong pull-up pulse, in cpu clocks
    localparam int unsigned STRONG_CLKS = 2;

    typedef enum logic [3:0] {
        PPM_QUASI  = 4'h1,
        PPM_PUSH   = 4'h2,
        PPM_INONLY = 4'h4,
        PPM_OPEN   = 4'h8
    } ppm_mode_e;

    typedef struct packed {
        logic pull_down;
        logic strong_up;
        logic weak_up;
        logic vweak_up;
    } ppm_pad_s;
endpackage : ppm_pkg

// ==== rtl/ppm_port_mode.sv ====
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - five ports, zero to four, each own a pair of mode-select registers.
// - every pin is set on its own to quasi, push-pull, open-drain or input-only.
// - bit y of a port's mode registers steers pin y of that port.
// - low,high bits 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - port four keeps only bits three to zero; upper bits read zero.
// - quasi pins drive high weakly and low strongly, usable as input too.
// - quasi very-weak pull-up is on whenever the latch holds one.
// - quasi weak pull-up is on only while latch and sensed pin are both one.
// - a quasi latch rising zero to one turns the strong pull-up on for two clocks.
// - open-drain has no pull-ups and pulls down only while the latch is zero.
// - open-drain pull-down and input path match quasi mode.
// - all mode registers reset to zero, so pins start in quasi mode.
// - input-only pins have neither pull-up nor pull-down.
// - push-pull keeps the strong pull-up on while the latch holds one.
module ppm_port_mode (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    input  wire logic [9:0]                   i_avs_address,
    input  wire logic                         i_avs_read,
    input  wire logic                         i_avs_write,
    input  wire logic [31:0]                  i_avs_writedata,
    input  wire logic [3:0]                   i_avs_byteenable,
    output logic      [31:0]                  o_avs_readdata,
    output logic                              o_avs_waitrequest,
    input  wire logic [ppm_pkg::NUM_PORTS*ppm_pkg::PIN_W-1:0] i_port_latch,
    input  wire logic [ppm_pkg::NUM_PORTS*ppm_pkg::PIN_W-1:0] i_pin_level,
    output logic      [ppm_pkg::NUM_PORTS*ppm_pkg::PIN_W-1:0] o_pin_sensed,
    output ppm_pkg::ppm_pad_s [ppm_pkg::NUM_PORTS*ppm_pkg::PIN_W-1:0] o_pad
);
    localparam int unsigned NP = ppm_pkg::NUM_PORTS * ppm_pkg::PIN_W;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] mode_low_reg  [ppm_pkg::NUM_PORTS];
    logic [7:0] mode_high_reg [ppm_pkg::NUM_PORTS];
    logic       ack_reg;
    logic [31:0] rdata_reg;

    // returns {hit, high, port}
    function automatic logic [4:0] ppm_decode(input logic [7:0] idx);
        case (idx)
            ppm_pkg::IDX_P0_LOW:  ppm_decode = 5'h10;
            ppm_pkg::IDX_P0_HIGH: ppm_decode = 5'h18;
            ppm_pkg::IDX_P1_LOW:  ppm_decode = 5'h11;
            ppm_pkg::IDX_P1_HIGH: ppm_decode = 5'h19;
            ppm_pkg::IDX_P2_LOW:  ppm_decode = 5'h12;
            ppm_pkg::IDX_P2_HIGH: ppm_decode = 5'h1A;
            ppm_pkg::IDX_P3_LOW:  ppm_decode = 5'h13;
            ppm_pkg::IDX_P3_HIGH: ppm_decode = 5'h1B;
            ppm_pkg::IDX_P4_LOW:  ppm_decode = 5'h14;
            ppm_pkg::IDX_P4_HIGH: ppm_decode = 5'h1C;
            default:              ppm_decode = 5'h00;
        endcase
    endfunction : ppm_decode

    logic [4:0] dec;
    logic       req;
    assign dec = ppm_decode(i_avs_address[9:2]);
    assign req = (i_avs_read | i_avs_write) & ~ack_reg;
    // one wait cycle per access, released at the acknowledge edge
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int p = 0; p < ppm_pkg::NUM_PORTS; p++) begin
                mode_low_reg[p]  <= ppm_pkg::MODE_RESET;
                mode_high_reg[p] <= ppm_pkg::MODE_RESET;
            end
        end else if (i_avs_write && ack_reg && dec[4] && i_avs_byteenable[0]) begin
            if (dec[3]) begin
                mode_high_reg[dec[2:0]] <= (dec[2:0] == 3'h4) ?
                    (i_avs_writedata[7:0] & ppm_pkg::P4_MASK) : i_avs_writedata[7:0];
            end else begin
                mode_low_reg[dec[2:0]] <= (dec[2:0] == 3'h4) ?
                    (i_avs_writedata[7:0] & ppm_pkg::P4_MASK) : i_avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_avs_read && !ack_reg) begin
            if (!dec[4]) begin
                rdata_reg <= ppm_pkg::UNMAPPED_RD;
            end else if (dec[3]) begin
                rdata_reg <= {24'h00_0000, mode_high_reg[dec[2:0]]};
            end else begin
                rdata_reg <= {24'h00_0000, mode_low_reg[dec[2:0]]};
            end
        end
    end
    assign o_avs_readdata = rdata_reg;

    // ------------------------------------------------------------
    // pin input sync and latch edge
    // ------------------------------------------------------------
    logic [NP-1:0] sync1_reg;
    logic [NP-1:0] sync2_reg;
    logic [NP-1:0] sync3_reg;
    logic [NP-1:0] sensed_reg;
    logic [NP-1:0] latch_q_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            sync3_reg  <= '0;
            sensed_reg <= '0;
        end else begin
            sync1_reg <= i_pin_level;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            // a change counts once stages two and three agree
            for (int i = 0; i < NP; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    sensed_reg[i] <= sync3_reg[i];
                end
            end
        end
    end
    // same input path in all modes
    assign o_pin_sensed = sensed_reg;

    // ------------------------------------------------------------
    // per-pin pad control
    // ------------------------------------------------------------
    logic [1:0] pulse_reg [NP];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // history starts high: a latch already high at release
            // must not fire a strong pulse
            latch_q_reg <= '1;
        end else begin
            latch_q_reg <= i_port_latch;
        end
    end

    function automatic ppm_pkg::ppm_mode_e ppm_mode(input logic lo, input logic hi);
        case ({lo, hi})
            2'b00:   ppm_mode = ppm_pkg::PPM_QUASI;
            2'b01:   ppm_mode = ppm_pkg::PPM_PUSH;
            2'b10:   ppm_mode = ppm_pkg::PPM_INONLY;
            default: ppm_mode = ppm_pkg::PPM_OPEN;
        endcase
    endfunction : ppm_mode

    ppm_pkg::ppm_mode_e pin_mode [NP];

    for (genvar g = 0; g < NP; g++) begin : g_pin
        localparam int PORT = g / ppm_pkg::PIN_W;
        localparam int BIT  = g % ppm_pkg::PIN_W;
        logic pin_mode_low_bit;
        logic pin_mode_high_bit;
        logic rise;
        assign pin_mode_low_bit  = mode_low_reg[PORT][BIT];
        assign pin_mode_high_bit = mode_high_reg[PORT][BIT];
        assign pin_mode[g] = ppm_mode(pin_mode_low_bit, pin_mode_high_bit);
        assign rise = i_port_latch[g] & ~latch_q_reg[g];

        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                pulse_reg[g] <= 2'h0;
            end else if (rise && pin_mode[g] == ppm_pkg::PPM_QUASI) begin
                pulse_reg[g] <= 2'(ppm_pkg::STRONG_CLKS);
            end else if (pulse_reg[g] != 2'h0 && i_port_latch[g]) begin
                pulse_reg[g] <= pulse_reg[g] - 2'h1;
            end else begin
                pulse_reg[g] <= 2'h0;
            end
        end

        always_comb begin
            o_pad[g] = '0;
            case (pin_mode[g])
                ppm_pkg::PPM_QUASI: begin
                    o_pad[g].pull_down = ~i_port_latch[g];
                    o_pad[g].vweak_up  = i_port_latch[g];
                    o_pad[g].weak_up   = i_port_latch[g] & sensed_reg[g];
                    o_pad[g].strong_up = i_port_latch[g] & (pulse_reg[g] != 2'h0);
                end
                ppm_pkg::PPM_PUSH: begin
                    o_pad[g].pull_down = ~i_port_latch[g];
                    o_pad[g].strong_up = i_port_latch[g];
                end
                ppm_pkg::PPM_INONLY: begin
                    o_pad[g] = '0;
                end
                ppm_pkg::PPM_OPEN: begin
                    o_pad[g].pull_down = ~i_port_latch[g];
                end
                default: begin
                    o_pad[g] = '0;
                end
            endcase
        end

        // ------------------------------------------------------------
        // per-pin checks
        // ------------------------------------------------------------
        // counter loads on the edge after the rise, so the strong
        // clocks are the two cycles after the rise cycle
        a_strong_two_clk: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            (rise && pin_mode[g] == ppm_pkg::PPM_QUASI ##1 i_port_latch[g]
             && pin_mode[g] == ppm_pkg::PPM_QUASI) |-> o_pad[g].strong_up)
            else $error("strong pull-up missing after latch rise");
        a_strong_second: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            (rise && pin_mode[g] == ppm_pkg::PPM_QUASI ##1 i_port_latch[g] ##1
             i_port_latch[g] && pin_mode[g] == ppm_pkg::PPM_QUASI) |-> o_pad[g].strong_up)
            else $error("strong pull-up missing in second clock");
        a_strong_ends: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            (rise && pin_mode[g] == ppm_pkg::PPM_QUASI ##2 !rise
             ##1 pin_mode[g] == ppm_pkg::PPM_QUASI) |-> !o_pad[g].strong_up)
            else $error("strong pull-up held past two clocks");
        a_weak_up_qb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            pin_mode[g] == ppm_pkg::PPM_QUASI |->
            o_pad[g].weak_up == (i_port_latch[g] && o_pin_sensed[g]))
            else $error("weak pull-up wrong in quasi mode");
        a_vweak_qb: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            pin_mode[g] == ppm_pkg::PPM_QUASI |-> o_pad[g].vweak_up == i_port_latch[g])
            else $error("very-weak pull-up wrong in quasi mode");
        a_open_drain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            pin_mode[g] == ppm_pkg::PPM_OPEN |-> !o_pad[g].strong_up && !o_pad[g].weak_up
            && !o_pad[g].vweak_up && o_pad[g].pull_down == !i_port_latch[g])
            else $error("open-drain pad wrong");
        a_input_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            pin_mode[g] == ppm_pkg::PPM_INONLY |-> o_pad[g] == '0)
            else $error("input-only pin driven");
        a_push_pull: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            pin_mode[g] == ppm_pkg::PPM_PUSH |-> o_pad[g].strong_up == i_port_latch[g]
            && o_pad[g].pull_down == !i_port_latch[g])
            else $error("push-pull pad wrong");
        a_no_fight: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            o_pad[g].pull_down |-> !o_pad[g].strong_up && !o_pad[g].weak_up
            && !o_pad[g].vweak_up)
            else $error("pull-down on together with a pull-up");
        a_latch_low_ups: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            !i_port_latch[g] |-> !o_pad[g].strong_up && !o_pad[g].weak_up && !o_pad[g].vweak_up)
            else $error("pull-up on while the latch holds zero");
        a_sensed_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
            sync2_reg[g] != sync3_reg[g] |=> $stable(o_pin_sensed[g]))
            else $error("sensed level moved before the stages agreed");
    end

    // ------------------------------------------------------------
    // bus and register checks
    // ------------------------------------------------------------
    a_p4_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (mode_low_reg[4][7:4] == 4'h0) && (mode_high_reg[4][7:4] == 4'h0))
        else $error("port four upper mode bits set");
    a_wait_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("write not answered in one wait cycle");
    a_wait_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("read not answered in one wait cycle");
    a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_avs_read && !ack_reg && !dec[4] |=> o_avs_readdata == ppm_pkg::UNMAPPED_RD)
        else $error("unmapped read not zero");
    a_rdata_upper: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    // a write lands only at the edge where waitrequest is low
    a_write_lands: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_avs_write && !o_avs_waitrequest && dec == 5'h10 && i_avs_byteenable[0]
        |=> mode_low_reg[0] == $past(i_avs_writedata[7:0]))
        else $error("write to port zero low register lost");
    a_be_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_avs_write && !o_avs_waitrequest && dec == 5'h10 && !i_avs_byteenable[0]
        |=> $stable(mode_low_reg[0]))
        else $error("write without byte lane zero changed a register");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    c_qb_pulse: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        g_pin[8].rise && pin_mode[8] == ppm_pkg::PPM_QUASI ##3 !o_pad[8].strong_up);
    c_write_p4: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_avs_write && ack_reg && dec == 5'h14);
    c_open_mode: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        pin_mode[9] == ppm_pkg::PPM_OPEN);
    c_push_high: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        pin_mode[0] == ppm_pkg::PPM_PUSH && o_pad[0].strong_up);
    c_input_only: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        pin_mode[16] == ppm_pkg::PPM_INONLY);
endmodule : ppm_port_mode

// ==== testbench/ppm_pin_model.sv ====
`timescale 1ns/1ns
// ----------------------
// external pin circuitry
// ----------------------
module ppm_pin_model (
    input  wire logic                     i_clk,
    input  wire ppm_pkg::ppm_pad_s [39:0] i_pad,
    input  wire logic [39:0]              i_ext_low,
    output logic      [39:0]              o_level
);
    initial o_level = '0;
    // undriven pins wander, so a stale level never passes for a pull-up
    always @(posedge i_clk) begin
        for (int i = 0; i < 40; i++) begin
            if (i_pad[i].pull_down || i_ext_low[i])
                o_level[i] <= 1'b0;
            else if (i_pad[i].strong_up || i_pad[i].weak_up || i_pad[i].vweak_up)
                o_level[i] <= 1'b1;
            else
                o_level[i] <= ~o_level[i];
        end
    end
endmodule : ppm_pin_model

// ==== testbench/ppm_port_mode_tb.sv ====
`timescale 1ns/1ns
module ppm_port_mode_tb;
    // -----------
    // bench state
    // -----------
    logic                     i_clk = 1'b0;
    logic                     rst_n, rd, wr, wreq;
    logic [9:0]               adr;
    logic [31:0]              wd, rdat;
    logic [3:0]               be;
    logic [39:0]              latch, ext, lvl, sns;
    ppm_pkg::ppm_pad_s [39:0] pad;
    logic [9:0]               alo [5];
    logic [9:0]               ahi [5];
    logic [7:0]               shl [5];
    logic [7:0]               shh [5];
    logic [31:0]              seed = 32'h172B;
    logic [31:0]              rd_q [$];
    logic [15:0]              pad_q [$];
    logic [15:0]              pe;
    int                       n_mismatch = 0;
    int                       cmp_count = 0;
    int                       cyc = 0;

    always #4 i_clk = ~i_clk;

    ppm_port_mode i_dut (.i_clk(i_clk), .i_rst_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_port_latch(latch),
        .i_pin_level(lvl), .o_pin_sensed(sns), .o_pad(pad));
    ppm_pin_model i_pins (.i_clk(i_clk), .i_pad(pad), .i_ext_low(ext), .o_level(lvl));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // order {pull_down, strong, weak, very weak}; mode is {low bit, high bit}
    function automatic logic [3:0] expad(input logic [1:0] m, input logic l, input logic s);
        case (m)
            2'b00: return {~l, 1'b0, l & s, l};
            2'b01: return {~l, l, 2'b00};
            2'b10: return 4'h0;
            default: return {~l, 3'b000};
        endcase
    endfunction : expad

    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t readdata %h expected %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_pad(input logic [5:0] i, input logic [3:0] m, input logic [3:0] exp);
        cmp_count++;
        if ((pad[i] & m) !== (exp & m)) begin
            n_mismatch++;
            $display("CHECK FAILED %0t pad %0d is %b expected %b", $time, i, pad[i], exp);
        end
    endtask : cmp_pad

    task automatic cmp_sns(input logic [5:0] i, input logic exp);
        cmp_count++;
        if (sns[i] !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t sensed %0d is %b expected %b", $time, i, sns[i], exp);
        end
    endtask : cmp_sns

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] b);
        @(posedge i_clk);
        adr <= a;
        wr  <= w;
        rd  <= ~w;
        wd  <= {24'h000000, d};
        be  <= b;
        @(posedge i_clk);
        while (wreq !== 1'b0) @(posedge i_clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
        rd_q.push_back({24'h000000, exp});
        bus(1'b0, a, 8'h00, 4'hF);
    endtask : rdchk

    // entry: {pin, sense known, sense level, pad mask, pad}
    task automatic padchk(input int i);
        logic [1:0] m;
        logic [3:0] e;
        m = {shl[i / 8][i % 8], shh[i / 8][i % 8]};
        e = expad(m, latch[i], ~ext[i]);
        // a pin nobody pulls wanders, so its level is not checked
        pad_q.push_back({6'(i), (e[3] | ext[i] | (|e[2:0])), ~(e[3] | ext[i]),
            (m == 2'b01) ? 4'hC : 4'hF, e});
    endtask : padchk

    always @(posedge i_clk)
        if (rd === 1'b1 && wreq === 1'b0)
            cmp_rd(rdat, rd_q.pop_front());

    always @(negedge i_clk)
        if (pad_q.size() > 0) begin
            pe = pad_q.pop_front();
            cmp_pad(pe[15:10], pe[7:4], pe[3:0]);
            if (pe[9])
                cmp_sns(pe[15:10], pe[8]);
        end

    // hang guard, far beyond the fewer than one thousand cycles of the sequence
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    // --------------
    // main sequence
    // --------------
    initial begin
        rst_n = 1'b0; rd = 1'b0; wr = 1'b0; adr = '0; wd = '0; be = '0;
        latch = '0; ext = '0;
        alo = '{{ppm_pkg::IDX_P0_LOW, 2'b00}, {ppm_pkg::IDX_P1_LOW, 2'b00},
            {ppm_pkg::IDX_P2_LOW, 2'b00}, {ppm_pkg::IDX_P3_LOW, 2'b00},
            {ppm_pkg::IDX_P4_LOW, 2'b00}};
        ahi = '{{ppm_pkg::IDX_P0_HIGH, 2'b00}, {ppm_pkg::IDX_P1_HIGH, 2'b00},
            {ppm_pkg::IDX_P2_HIGH, 2'b00}, {ppm_pkg::IDX_P3_HIGH, 2'b00},
            {ppm_pkg::IDX_P4_HIGH, 2'b00}};
        repeat (3) @(posedge i_clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            rdchk(alo[p], 8'h00);
            rdchk(ahi[p], 8'h00);
        end
        bus(1'b1, 10'h3FC, 8'hFF, 4'hF);
        rdchk(10'h3FC, 8'h00);
        for (int r = 0; r < 6; r++) begin
            for (int p = 0; p < 5; p++) begin
                seed = lfsr(seed);
                shl[p] = seed[7:0] & ((p == 4) ? 8'h0F : 8'hFF);
                shh[p] = seed[15:8] & ((p == 4) ? 8'h0F : 8'hFF);
                bus(1'b1, alo[p], seed[7:0], 4'hF);
                bus(1'b1, ahi[p], seed[15:8], 4'hF);
                rdchk(alo[p], shl[p]);
                rdchk(ahi[p], shh[p]);
            end
            seed = lfsr(seed);
            latch <= {seed[7:0], seed};
            seed = lfsr(seed);
            ext <= {seed[15:8], seed};
            repeat (12) @(posedge i_clk);
            for (int i = 0; i < 36; i++) padchk(i);
            while (pad_q.size() > 0) @(posedge i_clk);
        end
        bus(1'b1, alo[0], ~shl[0], 4'hE);
        rdchk(alo[0], shl[0]);
        bus(1'b1, alo[1], 8'h00, 4'hF);
        bus(1'b1, ahi[1], 8'h00, 4'hF);
        latch[8] <= 1'b0;
        ext[8] <= 1'b0;
        repeat (12) @(posedge i_clk);
        latch[8] <= 1'b1;
        // pulse counter loads on the next edge: strong in the two cycles after
        pad_q.push_back({6'h08, 2'h0, 4'h4, 4'h0});
        pad_q.push_back({6'h08, 2'h0, 4'h4, 4'h4});
        pad_q.push_back({6'h08, 2'h0, 4'h4, 4'h4});
        pad_q.push_back({6'h08, 2'h0, 4'h4, 4'h0});
        repeat (12) @(posedge i_clk);
        pad_q.push_back({6'h08, 2'h3, 4'hF, 4'h3});
        repeat (4) @(posedge i_clk);
        wrap_up();
    end
endmodule : ppm_port_mode_tb
